// ### core/csaq_compare_core.sv
// Primary compare shadow/active store, register port and output-A action logic
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module csaq_compare_core (
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic [7:0]         bus_addr_in,
	input  wire logic [31:0]        bus_wdata_in,
	input  wire logic               bus_wr_in,
	input  wire logic               bus_rd_in,
	output logic [31:0]             bus_rdata_out,
	input  wire csaq_pkg::csaq_tb_t timebase_in,
	output csaq_pkg::csaq_cmp_t     active_compare_out,
	output logic                    pwm_output_a_out
);
	csaq_pkg::csaq_cmp_t shadow_r, shadow_nxt;
	csaq_pkg::csaq_cmp_t active_r, active_nxt;
	logic                pending_r, pending_nxt;
	logic                buf_sel_r, buf_sel_nxt;
	logic [1:0]          load_evt_r, load_evt_nxt;
	logic [15:0]         act_ctrl_r, act_ctrl_nxt;
	logic [15:0]         secondary_compare_value_r, secondary_compare_value_nxt;
	logic [31:0]         rdata_r, rdata_nxt;
	logic                pwm_r, pwm_nxt;

	logic                wr_coarse;
	logic                wr_wide;
	logic                wr_fine;
	logic [15:0]         coarse_val;
	logic [7:0]          fine_val;
	logic                load_strobe;
	logic                prim_match;
	logic                sec_match;
	logic [3:0]          fire;
	logic                act_hit;

	// Address decode shared by the write path and the checks
	function automatic logic hit2(input logic [7:0] a, input logic [7:0] o1, input logic [7:0] o2);
		return (a == o1) || (a == o2);
	endfunction : hit2

	// Write classification; normal and mirror locations write alike
	assign wr_coarse = bus_wr_in && hit2(bus_addr_in, csaq_pkg::OFS_CMP_COARSE, csaq_pkg::OFS_CMP_MIRROR);
	assign wr_wide   = bus_wr_in && (bus_addr_in == csaq_pkg::OFS_CMP_WIDE);
	assign wr_fine   = bus_wr_in && hit2(bus_addr_in, csaq_pkg::OFS_CMP_FINE, csaq_pkg::OFS_FINE_MIRROR);
	assign coarse_val = wr_wide ? bus_wdata_in[csaq_pkg::WIDE_CRS_LSB +: 16] : bus_wdata_in[15:0];
	// Fine byte is in bits 15..8 for both the 16-bit and the wide layouts
	assign fine_val = bus_wdata_in[csaq_pkg::FINE_LSB +: 8];

	// Load strobe only in shadow mode and only on a counter update
	always_comb begin
		load_strobe = 1'b0;
		if (!buf_sel_r && timebase_in.tick) begin
			unique case (load_evt_r)
				csaq_pkg::LOAD_ZERO:   load_strobe = timebase_in.zero;
				csaq_pkg::LOAD_PRD:    load_strobe = timebase_in.period;
				csaq_pkg::LOAD_EITHER: load_strobe = timebase_in.zero | timebase_in.period;
				csaq_pkg::LOAD_FREEZE: load_strobe = 1'b0;
			endcase
		end
	end

	// Compare store: a write in the load cycle lands in the shadow after the transfer
	always_comb begin
		shadow_nxt = shadow_r;
		active_nxt = active_r;
		if (load_strobe) begin
			active_nxt = shadow_r;
		end
		if (wr_coarse || wr_wide) begin
			shadow_nxt.coarse = coarse_val;
			if (buf_sel_r) begin
				active_nxt.coarse = coarse_val;
			end
		end
		if (wr_fine || wr_wide) begin
			shadow_nxt.fine = fine_val;
			if (buf_sel_r) begin
				active_nxt.fine = fine_val;
			end
		end
	end

	// Pending flag; a set in the load cycle wins so a fresh value is never hidden
	always_comb begin
		pending_nxt = pending_r;
		if (load_strobe) begin
			pending_nxt = 1'b0;
		end
		if (!buf_sel_r && (wr_coarse || wr_wide)) begin
			pending_nxt = 1'b1;
		end
	end

	// Control registers; unused bits are dropped on write
	always_comb begin
		buf_sel_nxt  = buf_sel_r;
		load_evt_nxt = load_evt_r;
		act_ctrl_nxt = act_ctrl_r;
		secondary_compare_value_nxt     = secondary_compare_value_r;
		if (bus_wr_in) begin
			unique case (bus_addr_in)
				csaq_pkg::OFS_BUF_CTRL: begin
					buf_sel_nxt  = bus_wdata_in[csaq_pkg::BUF_SEL_BIT];
					load_evt_nxt = bus_wdata_in[csaq_pkg::LOAD_EVT_LSB +: 2];
				end
				csaq_pkg::OFS_ACT_CTRL: act_ctrl_nxt = bus_wdata_in[15:0] & csaq_pkg::ACT_CTRL_MASK;
				csaq_pkg::OFS_SECONDARY_COMPARE_VALUE:     secondary_compare_value_nxt = bus_wdata_in[15:0];
				default:                ;
			endcase
		end
	end

	// Read mux; data stand only in the cycle after the strobe
	always_comb begin
		rdata_nxt = csaq_pkg::RD_ZERO;
		if (bus_rd_in) begin
			unique case (bus_addr_in)
				csaq_pkg::OFS_BUF_CTRL: begin
					rdata_nxt[csaq_pkg::PENDING_BIT] = pending_r;
					rdata_nxt[csaq_pkg::BUF_SEL_BIT] = buf_sel_r;
					rdata_nxt[csaq_pkg::LOAD_EVT_LSB +: 2] = load_evt_r;
				end
				csaq_pkg::OFS_CMP_COARSE: rdata_nxt[15:0] = buf_sel_r ? active_r.coarse : shadow_r.coarse;
				csaq_pkg::OFS_CMP_FINE:
					rdata_nxt[csaq_pkg::FINE_LSB +: 8] = buf_sel_r ? active_r.fine : shadow_r.fine;
				csaq_pkg::OFS_CMP_WIDE: begin
					rdata_nxt[csaq_pkg::WIDE_CRS_LSB +: 16] = buf_sel_r ? active_r.coarse : shadow_r.coarse;
					rdata_nxt[csaq_pkg::FINE_LSB +: 8] = buf_sel_r ? active_r.fine : shadow_r.fine;
				end
				csaq_pkg::OFS_CMP_MIRROR: rdata_nxt[15:0] = active_r.coarse;
				csaq_pkg::OFS_ACT_CTRL:   rdata_nxt[15:0] = act_ctrl_r;
				csaq_pkg::OFS_SECONDARY_COMPARE_VALUE:       rdata_nxt[15:0] = secondary_compare_value_r;
				// Fine mirror reads carry nothing useful, so they return zero like a hole
				default:                  rdata_nxt = csaq_pkg::RD_ZERO;
			endcase
		end
	end

	// Match events, one per counter update so a held count never retriggers a toggle
	assign prim_match = timebase_in.tick && (timebase_in.count == active_r.coarse);
	assign sec_match  = timebase_in.tick && (timebase_in.count == secondary_compare_value_r);
	assign fire = {sec_match & timebase_in.down, sec_match & ~timebase_in.down,
		prim_match & timebase_in.down, prim_match & ~timebase_in.down};

	csaq_action_unit u_action (
		.act_ctrl_in   (act_ctrl_r),
		.fire_in       (fire),
		.level_in      (pwm_r),
		.level_nxt_out (pwm_nxt),
		.hit_out       (act_hit)
	);

	// All state registered here
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			shadow_r   <= '{coarse: csaq_pkg::RST_HALF, fine: csaq_pkg::RST_FINE};
			active_r   <= '{coarse: csaq_pkg::RST_HALF, fine: csaq_pkg::RST_FINE};
			pending_r  <= 1'b0;
			buf_sel_r  <= 1'b0;
			load_evt_r <= csaq_pkg::LOAD_ZERO;
			act_ctrl_r <= csaq_pkg::RST_HALF;
			secondary_compare_value_r     <= csaq_pkg::RST_HALF;
			rdata_r    <= csaq_pkg::RD_ZERO;
			pwm_r      <= 1'b0;
		end else begin
			shadow_r   <= shadow_nxt;
			active_r   <= active_nxt;
			pending_r  <= pending_nxt;
			buf_sel_r  <= buf_sel_nxt;
			load_evt_r <= load_evt_nxt;
			act_ctrl_r <= act_ctrl_nxt;
			secondary_compare_value_r     <= secondary_compare_value_nxt;
			rdata_r    <= rdata_nxt;
			pwm_r      <= pwm_nxt;
		end
	end

	assign bus_rdata_out      = rdata_r;
	assign active_compare_out = active_r;
	assign pwm_output_a_out   = pwm_r;

	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_shadow_coarse_wr;
		!buf_sel_r && (wr_coarse || wr_wide);
	endsequence

	sequence s_quiet_store;
		!wr_coarse && !wr_wide && !wr_fine;
	endsequence

	chk_pending_set: assert property (s_shadow_coarse_wr |=> pending_r)
		else $error("pending flag not set by coarse write");
	chk_fine_keeps_flag: assert property (wr_fine && !load_strobe |=> pending_r == $past(pending_r))
		else $error("fine write changed pending flag");
	chk_pending_clear: assert property (load_strobe and s_quiet_store |=> !pending_r)
		else $error("pending flag not cleared by load");
	chk_shadow_load: assert property (load_strobe and s_quiet_store |=> active_r == $past(shadow_r))
		else $error("shadow not moved to active on load");
	chk_freeze_hold: assert property ((!buf_sel_r && load_evt_r == csaq_pkg::LOAD_FREEZE) and s_quiet_store
		|=> active_r == $past(active_r))
		else $error("active changed while frozen");
	chk_immediate_wr: assert property (buf_sel_r && wr_coarse |=> active_r.coarse == $past(bus_wdata_in[15:0]))
		else $error("immediate write missed active");
	// Read data stand one cycle, then fall to zero unless a further read follows
	chk_mirror_read: assert property (bus_rd_in && bus_addr_in == csaq_pkg::OFS_CMP_MIRROR
		|=> bus_rdata_out == {16'h0000, $past(active_r.coarse)}
		##1 (bus_rdata_out == csaq_pkg::RD_ZERO || $past(bus_rd_in)))
		else $error("mirror read not active value");
	chk_fine_mirror_rd: assert property (bus_rd_in && bus_addr_in == csaq_pkg::OFS_FINE_MIRROR
		|=> bus_rdata_out == csaq_pkg::RD_ZERO)
		else $error("fine mirror read not zero");
	chk_up_low: assert property (fire == 4'h1 && act_ctrl_r[csaq_pkg::ACT_PUP_LSB +: 2] == csaq_pkg::ACT_LOW
		|=> !pwm_output_a_out)
		else $error("primary up clear not applied");
	chk_down_toggle: assert property (fire == 4'h8 && act_ctrl_r[csaq_pkg::ACT_SDN_LSB +: 2] == csaq_pkg::ACT_TOGGLE
		|=> pwm_output_a_out != $past(pwm_output_a_out))
		else $error("secondary down toggle not applied");
	chk_hold_level: assert property (!act_hit |=> $stable(pwm_output_a_out))
		else $error("output moved with no action");
endmodule : csaq_compare_core
`default_nettype wire

// ### core/csaq_pkg.sv
// Constants, field layouts and carrier types of the primary compare and output-A action block
package csaq_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned HALF_W = 16;

	// Register byte addresses
	localparam logic [7:0] OFS_BUF_CTRL    = 8'h00;
	localparam logic [7:0] OFS_CMP_COARSE  = 8'h04;
	localparam logic [7:0] OFS_CMP_FINE    = 8'h08;
	localparam logic [7:0] OFS_CMP_WIDE    = 8'h0C;
	localparam logic [7:0] OFS_CMP_MIRROR  = 8'h10;
	localparam logic [7:0] OFS_FINE_MIRROR = 8'h14;
	localparam logic [7:0] OFS_ACT_CTRL    = 8'h18;
	localparam logic [7:0] OFS_SECONDARY_COMPARE_VALUE        = 8'h1C;

	// Field positions
	localparam int unsigned LOAD_EVT_LSB = 0;
	localparam int unsigned BUF_SEL_BIT  = 4;
	localparam int unsigned PENDING_BIT  = 8;
	localparam int unsigned FINE_LSB     = 8;
	localparam int unsigned WIDE_CRS_LSB = 16;
	localparam int unsigned ACT_PUP_LSB  = 4;
	localparam int unsigned ACT_PDN_LSB  = 6;
	localparam int unsigned ACT_SUP_LSB  = 8;
	localparam int unsigned ACT_SDN_LSB  = 10;
	localparam int unsigned N_EVENTS     = 4;

	// Writable bits of the action register; zero and period actions live elsewhere
	localparam logic [15:0] ACT_CTRL_MASK = 16'h0FF0;

	// Action codes
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_LOW    = 2'h1;
	localparam logic [1:0] ACT_HIGH   = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;

	// Load event codes
	localparam logic [1:0] LOAD_ZERO   = 2'h0;
	localparam logic [1:0] LOAD_PRD    = 2'h1;
	localparam logic [1:0] LOAD_EITHER = 2'h2;
	localparam logic [1:0] LOAD_FREEZE = 2'h3;

	// Reset values
	localparam logic [15:0] RST_HALF = 16'h0000;
	localparam logic [7:0]  RST_FINE = 8'h00;
	localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

	typedef struct packed {
		logic [15:0] count;
		logic        tick;
		logic        down;
		logic        zero;
		logic        period;
	} csaq_tb_t;

	typedef struct packed {
		logic [15:0] coarse;
		logic [7:0]  fine;
	} csaq_cmp_t;

	// Next level after one action on the current level
	function automatic logic apply_action(input logic [1:0] act, input logic lvl);
		unique case (act)
			ACT_LOW:    return 1'b0;
			ACT_HIGH:   return 1'b1;
			ACT_TOGGLE: return ~lvl;
			default:    return lvl;
		endcase
	endfunction : apply_action
endpackage : csaq_pkg

// ### core/csaq_action_unit.sv
// Priority resolver for the four compare-match actions on output A
`timescale 1ns/1ps
`default_nettype none
module csaq_action_unit (
	input  wire logic [15:0] act_ctrl_in,
	input  wire logic [3:0]  fire_in,
	input  wire logic        level_in,
	output logic             level_nxt_out,
	output logic             hit_out
);
	localparam int unsigned LSBS [4] = '{csaq_pkg::ACT_PUP_LSB, csaq_pkg::ACT_PDN_LSB,
		csaq_pkg::ACT_SUP_LSB, csaq_pkg::ACT_SDN_LSB};

	logic [4:0] lvl_chain;
	logic [4:0] hit_chain;

	assign lvl_chain[0] = level_in;
	assign hit_chain[0] = 1'b0;

	// Later events win; each works on the present level so a toggle is never stacked
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_evt
			logic [1:0] code;
			logic       hit;
			assign code = act_ctrl_in[LSBS[g] +: 2];
			assign hit = fire_in[g] && (code != csaq_pkg::ACT_NONE);
			assign lvl_chain[g+1] = hit ? csaq_pkg::apply_action(code, level_in) : lvl_chain[g];
			assign hit_chain[g+1] = hit_chain[g] | hit;
		end
	endgenerate

	// With no enabled action the level passes through unchanged
	assign level_nxt_out = lvl_chain[4];
	assign hit_out = hit_chain[4];
endmodule : csaq_action_unit
`default_nettype wire

// ### verification/test_compare_shadow_action_qualifier.sv
// Self-checking bench for the primary compare store and the output-A actions
`timescale 1ns/1ps
`default_nettype none
module test_compare_shadow_action_qualifier;
	logic                clk_in;
	logic                rst_n_in;
	logic [7:0]          addr;
	logic [31:0]         wdata;
	logic                wr;
	logic                rd;
	logic [31:0]         rdata;
	csaq_pkg::csaq_tb_t  tb;
	csaq_pkg::csaq_cmp_t act;
	logic                pwm;
	int                  bad_count;
	int                  n_compared;
	logic [23:0]         e_act;
	logic [15:0]         val;
	logic [7:0]          fine;
	logic [1:0]          code;
	logic                lvl;
	logic [15:0]         cnt;
	logic [1:0]          seq [5];

	csaq_compare_core dut (
		.clk_in             (clk_in),
		.rst_n_in           (rst_n_in),
		.bus_addr_in        (addr),
		.bus_wdata_in       (wdata),
		.bus_wr_in          (wr),
		.bus_rd_in          (rd),
		.bus_rdata_out      (rdata),
		.timebase_in        (tb),
		.active_compare_out (act),
		.pwm_output_a_out   (pwm)
	);

	// 250 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	// One strobe cycle; the #1 lets the registers of the taking edge land
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe, so sample there
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rd_reg

	// One counter step with tick high
	task automatic pulse(input logic [15:0] c, input logic d, input logic z, input logic p);
		@(posedge clk_in);
		tb <= '{count: c, tick: 1'b1, down: d, zero: z, period: p};
		@(posedge clk_in);
		tb.tick <= 1'b0;
		#1;
	endtask : pulse

	task automatic chk_act(input logic [23:0] e);
		chk({8'h00, act}, {8'h00, e});
	endtask : chk_act

	task automatic finish_test();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	// Watchdog far beyond the few hundred cycles the tests need
	initial begin
		#40000;
		bad_count++;
		finish_test();
	end

	initial begin
		rst_n_in = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wr = 1'b0;
		rd = 1'b0;
		tb = '0;
		e_act = 24'h00_0000;
		seq = '{csaq_pkg::ACT_TOGGLE, csaq_pkg::ACT_NONE, csaq_pkg::ACT_LOW, csaq_pkg::ACT_HIGH, csaq_pkg::ACT_TOGGLE};
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rd_reg(csaq_pkg::OFS_BUF_CTRL, 32'h0000_0000);
		rd_reg(csaq_pkg::OFS_CMP_MIRROR, 32'h0000_0000);
		rd_reg(csaq_pkg::OFS_CMP_FINE, 32'h0000_0000);
		rd_reg(csaq_pkg::OFS_ACT_CTRL, 32'h0000_0000);
		chk({31'h0, pwm}, 32'h0000_0000);
		$display("test reset done");
		// Every load event code, with a zero step and then a period step
		for (int i = 0; i < 4; i++) begin
			code = i[1:0];
			val = {14'h0400, code};
			fine = {6'h28, code};
			wr_reg(csaq_pkg::OFS_BUF_CTRL, {30'h0, code});
			wr_reg(csaq_pkg::OFS_CMP_COARSE, {16'h0000, val});
			wr_reg(csaq_pkg::OFS_FINE_MIRROR, {16'h0000, fine, 8'h00});
			rd_reg(csaq_pkg::OFS_CMP_MIRROR, {16'h0000, e_act[23:8]});
			rd_reg(csaq_pkg::OFS_BUF_CTRL, {23'h0, 1'b1, 6'h0, code});
			pulse(16'h0000, 1'b0, 1'b1, 1'b0);
			if (code == csaq_pkg::LOAD_ZERO || code == csaq_pkg::LOAD_EITHER) e_act = {val, fine};
			chk_act(e_act);
			pulse(16'h0050, 1'b1, 1'b0, 1'b1);
			if (code == csaq_pkg::LOAD_PRD || code == csaq_pkg::LOAD_EITHER) e_act = {val, fine};
			chk_act(e_act);
			rd_reg(csaq_pkg::OFS_BUF_CTRL, {23'h0, code == csaq_pkg::LOAD_FREEZE, 6'h0, code});
		end
		rd_reg(csaq_pkg::OFS_FINE_MIRROR, 32'h0000_0000);
		$display("test load events done");
		// Pending flag: cleared by a load, kept by fine writes, replaced value wins
		wr_reg(csaq_pkg::OFS_BUF_CTRL, 32'h0000_0000);
		pulse(16'h0000, 1'b0, 1'b1, 1'b0);
		chk_act(24'h1003A3);
		rd_reg(csaq_pkg::OFS_BUF_CTRL, 32'h0000_0000);
		wr_reg(csaq_pkg::OFS_CMP_FINE, 32'h0000_5500);
		rd_reg(csaq_pkg::OFS_BUF_CTRL, 32'h0000_0000);
		rd_reg(csaq_pkg::OFS_CMP_FINE, 32'h0000_5500);
		wr_reg(csaq_pkg::OFS_CMP_WIDE, 32'h5678_CD00);
		rd_reg(csaq_pkg::OFS_BUF_CTRL, 32'h0000_0100);
		wr_reg(csaq_pkg::OFS_CMP_WIDE, 32'h9ABC_EF00);
		rd_reg(csaq_pkg::OFS_CMP_WIDE, 32'h9ABC_EF00);
		rd_reg(csaq_pkg::OFS_CMP_MIRROR, 32'h0000_1003);
		pulse(16'h0000, 1'b0, 1'b1, 1'b0);
		chk_act(24'h9ABCEF);
		$display("test pending done");
		// Immediate mode goes straight to the active value
		wr_reg(csaq_pkg::OFS_BUF_CTRL, 32'h0000_0010);
		wr_reg(csaq_pkg::OFS_CMP_MIRROR, 32'h0000_0100);
		chk_act(24'h0100EF);
		wr_reg(csaq_pkg::OFS_FINE_MIRROR, 32'h0000_3300);
		chk_act(24'h010033);
		rd_reg(csaq_pkg::OFS_BUF_CTRL, 32'h0000_0010);
		$display("test immediate done");
		// Each match field through every code; the opposite direction must not act
		wr_reg(csaq_pkg::OFS_SECONDARY_COMPARE_VALUE, 32'h0000_0200);
		lvl = 1'b0;
		for (int e = 0; e < 4; e++) begin
			cnt = (e < 2) ? 16'h0100 : 16'h0200;
			for (int s = 0; s < 5; s++) begin
				wr_reg(csaq_pkg::OFS_ACT_CTRL, {30'h0, seq[s]} << (4 + 2 * e));
				pulse(cnt, e[0], 1'b0, 1'b0);
				if (seq[s] == csaq_pkg::ACT_LOW) lvl = 1'b0;
				else if (seq[s] == csaq_pkg::ACT_HIGH) lvl = 1'b1;
				else if (seq[s] == csaq_pkg::ACT_TOGGLE) lvl = ~lvl;
				chk({31'h0, pwm}, {31'h0, lvl});
				pulse(cnt, ~e[0], 1'b0, 1'b0);
				chk({31'h0, pwm}, {31'h0, lvl});
			end
		end
		wr_reg(csaq_pkg::OFS_ACT_CTRL, 32'h0000_FFFF);
		rd_reg(csaq_pkg::OFS_ACT_CTRL, 32'h0000_0FF0);
		rd_reg(8'hFC, 32'h0000_0000);
		$display("test actions done");
		finish_test();
	end
endmodule : test_compare_shadow_action_qualifier
`default_nettype wire
